// *** hdl/can_pm_pkg.sv ***
// Behaviour
// - Listen-only receives frames, sends only recessive, never starts transmitting.
// - Listen-only dominant bits loop back to the monitor; bus stays recessive.
// - Loopback routes transmit to receive, ignores receive pin, holds transmit high.
// - Loopback treats own frame as received, ignores ack slot, raises both irqs.
// - Module enable low stops all controller clocks regardless of other bits.
// - Sleep stops core clocks but keeps register access clocks running.
// - Power-down stops every clock.
// - Wake-up irq only with request, acknowledge, wake enable and irq enable.
// - CPU run mode allows only sleep, never power-down.
// - Wait with stop-in-wait powers down; leaving restarts into normal mode unless asleep.
// - Wait without stop-in-wait runs normally or sleeps per sleep bits.
// - Deep stops power down; light stop powers down unless asleep; stop-in-wait ignored.
// - On sleep request finish all transmit buffers, then sync delay, then sleep.
// - Finish a frame being received, sleep at idle; idle means sleep at once.
// - Acknowledge set when sleep active; software polls it, avoids racing flags.
// - Bus-off recovery count pauses in sleep, transmit recessive, resumes after.
// - Sleep keeps foreground readable, full flag clearable, blocks new moves.
// - Sleep defers aborts; pending copies, aborts, sends run on wake-up.
// - Without wake enable at sleep entry, receive line forced recessive; in listen-only the code still passes the receive pin through.
// - Sleep ends on bus activity with wake enable or request cleared.
// - After wake wait 11 recessive bits before joining; waking frame lost.
// - Power-down entry aborts transfers and forces transmit recessive at once.
package can_pm_pkg;
    localparam int          SYNC_DELAY_CYC  = 3;     // Sleep entry synchroniser delay
    localparam int          IDLE_BITS       = 11;    // Recessive bits for resync
    localparam logic [2:0]  CPU_RUN         = 3'h0;
    localparam logic [2:0]  CPU_WAIT        = 3'h1;
    localparam logic [2:0]  CPU_STOP3       = 3'h2;
    localparam logic [2:0]  CPU_STOP12      = 3'h3;
    localparam logic        RECESSIVE       = 1'b1;

    typedef enum logic [4:0] {
        ST_NORMAL   = 5'b0_0001,
        ST_DRAIN    = 5'b0_0010,
        ST_SYNC     = 5'b0_0100,
        ST_SLEEP    = 5'b0_1000,
        ST_RESYNC   = 5'b1_0000
    } pm_state_t;

    // Control bits from software
    typedef struct packed {
        logic       module_enable;
        logic       stop_in_wait;
        logic       sleep_request;
        logic       wakeup_enable;
        logic       wakeup_irq_enable;
        logic       listen_only;
        logic       loopback;
    } pm_ctrl_t;

    // Status returned to software and core
    typedef struct packed {
        logic       sleep_acknowledge;
        logic       power_down;
        logic       core_clk_en;
        logic       reg_clk_en;
        logic       on_bus;
    } pm_stat_t;
endpackage

// *** hdl/can_mode_power_control.sv ***
`timescale 1ns/1ns
module can_mode_power_control #(
    parameter int NBUF = 3
) (
    // Clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    // Software control and CPU mode
    input  wire can_pm_pkg::pm_ctrl_t     ctrl_i,
    input  wire logic [2:0]               cpu_mode_i,
    input  wire logic [NBUF-1:0]          tx_buffer_empty_flag_i,
    // Protocol core side
    input  wire logic                     mac_tx_i,
    input  wire logic                     mac_tx_start_i,
    input  wire logic                     mac_receiving_i,
    input  wire logic                     mac_bit_tick_i,
    input  wire logic                     mac_tx_done_i,
    input  wire logic                     mac_rx_done_i,
    input  wire logic                     bus_off_i,
    input  wire logic                     ack_slot_i,
    output logic                          mac_rx_o,
    output logic                          tx_allowed_o,
    output logic                          ack_ignore_o,
    output logic                          abort_o,
    output logic                          fg_move_en_o,
    output logic                          abort_en_o,
    output logic                          busoff_count_en_o,
    output logic                          tx_irq_o,
    output logic                          rx_irq_o,
    output logic                          wakeup_irq_o,
    output can_pm_pkg::pm_stat_t          stat_o,
    // Bus pins
    input  wire logic                     bus_receive_pin_i,
    output logic                          bus_transmit_pin_o
);
    can_pm_pkg::pm_state_t state_q;
    logic [2:0]  rx_sync_q;
    logic        rx_pin_q;
    logic [3:0]  cnt_q;
    logic        wake_armed_q;
    logic        pd_q;
    logic        pd_d;
    logic        rx_int;
    logic        active;
    logic        all_empty;
    logic        wake_evt;

    assign all_empty = &tx_buffer_empty_flag_i;
    assign active    = ctrl_i.module_enable && !pd_q;

    // Power-down decode per CPU mode
    always_comb begin
        case (cpu_mode_i)
            can_pm_pkg::CPU_RUN:    pd_d = 1'b0;
            can_pm_pkg::CPU_WAIT:   pd_d = ctrl_i.stop_in_wait;
            can_pm_pkg::CPU_STOP3:  pd_d = state_q != can_pm_pkg::ST_SLEEP;
            default:                pd_d = 1'b1;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pd_q <= 1'b0;
        end else begin
            pd_q <= pd_d;
        end
    end

    // Receive pin synchroniser, change counted when stages two and three agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_sync_q <= 3'b111;
            rx_pin_q  <= can_pm_pkg::RECESSIVE;
        end else begin
            rx_sync_q <= {rx_sync_q[1:0], bus_receive_pin_i};
            if (rx_sync_q[1] == rx_sync_q[2]) begin
                rx_pin_q <= rx_sync_q[2];
            end
        end
    end

    // Internal receive path
    always_comb begin
        if (ctrl_i.loopback) begin
            rx_int = mac_tx_i;
        end else if (ctrl_i.listen_only) begin
            rx_int = rx_pin_q & mac_tx_i;
        end else if (state_q == can_pm_pkg::ST_SLEEP && !wake_armed_q) begin
            rx_int = can_pm_pkg::RECESSIVE;
        end else begin
            rx_int = rx_pin_q & mac_tx_i;
        end
    end

    assign wake_evt = state_q == can_pm_pkg::ST_SLEEP && wake_armed_q && !rx_int;

    // Sleep state machine
    always_ff @(posedge clk_i) begin
        if (rst_i || !ctrl_i.module_enable) begin
            state_q      <= can_pm_pkg::ST_NORMAL;
            cnt_q        <= '0;
            wake_armed_q <= 1'b0;
        end else if (!pd_q) begin
            case (state_q)
                can_pm_pkg::ST_NORMAL: begin
                    cnt_q <= '0;
                    if (ctrl_i.sleep_request) begin
                        state_q <= can_pm_pkg::ST_DRAIN;
                    end
                end
                can_pm_pkg::ST_DRAIN: begin
                    if (all_empty && !mac_receiving_i) begin
                        state_q <= can_pm_pkg::ST_SYNC;
                    end
                end
                can_pm_pkg::ST_SYNC: begin
                    cnt_q <= cnt_q + 4'd1;
                    if (cnt_q == 4'(can_pm_pkg::SYNC_DELAY_CYC - 1)) begin
                        state_q      <= can_pm_pkg::ST_SLEEP;
                        wake_armed_q <= ctrl_i.wakeup_enable;
                        cnt_q        <= '0;
                    end
                end
                can_pm_pkg::ST_SLEEP: begin
                    if (wake_evt || !ctrl_i.sleep_request) begin
                        state_q <= can_pm_pkg::ST_RESYNC;
                    end
                end
                can_pm_pkg::ST_RESYNC: begin
                    if (!rx_int) begin
                        cnt_q <= '0;
                    end else if (mac_bit_tick_i) begin
                        cnt_q <= cnt_q + 4'd1;
                    end
                    if (cnt_q == 4'(can_pm_pkg::IDLE_BITS)) begin
                        state_q <= can_pm_pkg::ST_NORMAL;
                        cnt_q   <= '0;
                    end
                end
                default: begin
                    state_q <= can_pm_pkg::ST_NORMAL;
                end
            endcase
        end else begin
            // Power-down restarts the controllers into normal unless they are asleep
            if (state_q != can_pm_pkg::ST_SLEEP) begin
                state_q <= can_pm_pkg::ST_NORMAL;
            end
        end
    end

    // Registered outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mac_rx_o           <= can_pm_pkg::RECESSIVE;
            bus_transmit_pin_o <= can_pm_pkg::RECESSIVE;
            tx_allowed_o       <= 1'b0;
            ack_ignore_o       <= 1'b0;
            abort_o            <= 1'b0;
            fg_move_en_o       <= 1'b0;
            abort_en_o         <= 1'b0;
            busoff_count_en_o  <= 1'b0;
            tx_irq_o           <= 1'b0;
            rx_irq_o           <= 1'b0;
            wakeup_irq_o       <= 1'b0;
            stat_o             <= '0;
        end else begin
            mac_rx_o <= rx_int;
            if (!active || ctrl_i.listen_only || ctrl_i.loopback
                    || state_q == can_pm_pkg::ST_SLEEP) begin
                bus_transmit_pin_o <= can_pm_pkg::RECESSIVE;
            end else begin
                bus_transmit_pin_o <= mac_tx_i;
            end
            tx_allowed_o <= active && !ctrl_i.listen_only
                            && state_q == can_pm_pkg::ST_NORMAL;
            ack_ignore_o <= ctrl_i.loopback && ack_slot_i;
            abort_o      <= ctrl_i.module_enable && pd_d && !pd_q;
            fg_move_en_o <= active && state_q != can_pm_pkg::ST_SLEEP;
            abort_en_o   <= active && state_q != can_pm_pkg::ST_SLEEP;
            busoff_count_en_o <= active && bus_off_i
                                 && state_q != can_pm_pkg::ST_SLEEP;
            tx_irq_o     <= active && mac_tx_done_i;
            rx_irq_o     <= active && (mac_rx_done_i
                            || (ctrl_i.loopback && mac_tx_done_i));
            wakeup_irq_o <= ctrl_i.module_enable && wake_evt && ctrl_i.sleep_request
                            && ctrl_i.wakeup_enable && ctrl_i.wakeup_irq_enable;
            stat_o.sleep_acknowledge <= ctrl_i.module_enable
                                        && state_q == can_pm_pkg::ST_SLEEP;
            stat_o.power_down  <= ctrl_i.module_enable && pd_q;
            stat_o.core_clk_en <= active && state_q != can_pm_pkg::ST_SLEEP;
            stat_o.reg_clk_en  <= active;
            stat_o.on_bus      <= active && state_q == can_pm_pkg::ST_NORMAL;
        end
    end

    // Checks
    sequence s_sleep_reached;
        state_q == can_pm_pkg::ST_SLEEP;
    endsequence

    property p_listen_tx;
        @(posedge clk_i) disable iff (rst_i) ctrl_i.listen_only |=> bus_transmit_pin_o;
    endproperty
    a_listen_tx: assert property (p_listen_tx) else $error("listen-only drove dominant");

    property p_loop_rx;
        @(posedge clk_i) disable iff (rst_i) ctrl_i.loopback |=> mac_rx_o == $past(mac_tx_i);
    endproperty
    a_loop_rx: assert property (p_loop_rx) else $error("loopback path broken");

    property p_sleep_ack;
        @(posedge clk_i) disable iff (rst_i) s_sleep_reached and ctrl_i.module_enable
            |=> stat_o.sleep_acknowledge;
    endproperty
    a_sleep_ack: assert property (p_sleep_ack) else $error("no acknowledge in sleep");

    property p_drain;
        @(posedge clk_i) disable iff (rst_i)
            state_q == can_pm_pkg::ST_DRAIN && !all_empty && !pd_q |=> state_q == can_pm_pkg::ST_DRAIN;
    endproperty
    a_drain: assert property (p_drain) else $error("sleep entered with pending tx");

    property p_run_no_pd;
        @(posedge clk_i) disable iff (rst_i) cpu_mode_i == can_pm_pkg::CPU_RUN |=> !pd_q;
    endproperty
    a_run_no_pd: assert property (p_run_no_pd) else $error("power-down in run");

    property p_wake_irq;
        @(posedge clk_i) disable iff (rst_i) wakeup_irq_o |-> $past(ctrl_i.wakeup_irq_enable)
            && $past(ctrl_i.sleep_request) && $past(state_q == can_pm_pkg::ST_SLEEP);
    endproperty
    a_wake_irq: assert property (p_wake_irq) else $error("spurious wake-up irq");

    property p_disabled_clk;
        @(posedge clk_i) disable iff (rst_i) !ctrl_i.module_enable |=> !stat_o.reg_clk_en;
    endproperty
    a_disabled_clk: assert property (p_disabled_clk) else $error("clock on while disabled");

    property p_sleep_busoff;
        @(posedge clk_i) disable iff (rst_i) s_sleep_reached |=> !busoff_count_en_o && !fg_move_en_o;
    endproperty
    a_sleep_busoff: assert property (p_sleep_busoff) else $error("activity during sleep");
endmodule

// *** tb/can_bus_node.sv ***
`timescale 1ns/1ns
// Remote node on a pulled-up bus, wired-AND with the dut transmit pin
module can_bus_node (
    // Clock and dut side
    input  wire logic clk_i,
    input  wire logic dut_tx_i,
    // Resolved bus level
    output logic      bus_o
);
    logic node_q = 1'b1;

    // Released bus returns to the recessive pull-up level
    assign bus_o = dut_tx_i & node_q;

    // Dominant burst of n cycles, then release
    task automatic burst(input int n);
        node_q <= 1'b0;
        repeat (n) @(posedge clk_i);
        node_q <= 1'b1;
    endtask
endmodule

// *** tb/can_mode_power_control_tb_top.sv ***
`timescale 1ns/1ns
module can_mode_power_control_tb_top;
    logic                 clk_i = 1'b0;
    logic                 rst_i = 1'b1;
    can_pm_pkg::pm_ctrl_t ctrl  = '0;
    can_pm_pkg::pm_stat_t stat;
    logic [2:0]           cpu_mode = 3'h0;
    logic [2:0]           txe = 3'h7;
    logic                 mac_tx = 1'b1, tick = 1'b0, tx_done = 1'b0, rcv = 1'b0, boff = 1'b0;
    logic                 ack_slot, mac_rx, tx_ok, ack_ign, abort, pin_tx, pin_rx, wk_irq;
    logic                 fg_en, ab_en, bo_en, tx_irq, rx_irq, pd;
    logic [31:0]          seed = 32'h72e4_ebca;
    logic [31:0]          r;
    logic                 q_exp[$];
    int                   error_cnt = 0;
    int                   n_compared = 0;
    int                   i, k, m_sleep;

    // Clock
    always #4 clk_i = ~clk_i;

    can_mode_power_control #(.NBUF(3)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .ctrl_i(ctrl), .cpu_mode_i(cpu_mode),
        .tx_buffer_empty_flag_i(txe), .mac_tx_i(mac_tx), .mac_tx_start_i(1'b0),
        .mac_receiving_i(rcv), .mac_bit_tick_i(tick), .mac_tx_done_i(tx_done),
        .mac_rx_done_i(1'b0), .bus_off_i(boff), .ack_slot_i(ack_slot), .mac_rx_o(mac_rx),
        .tx_allowed_o(tx_ok), .ack_ignore_o(ack_ign), .abort_o(abort), .fg_move_en_o(fg_en),
        .abort_en_o(ab_en), .busoff_count_en_o(bo_en), .tx_irq_o(tx_irq), .rx_irq_o(rx_irq),
        .wakeup_irq_o(wk_irq), .stat_o(stat), .bus_receive_pin_i(pin_rx),
        .bus_transmit_pin_o(pin_tx)
    );
    can_bus_node bus (.clk_i(clk_i), .dut_tx_i(pin_tx), .bus_o(pin_rx));
    assign pd = stat.power_down;
    assign ack_slot = 1'b1;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Reference model of the power-down decision
    function automatic logic exp_pd(logic [2:0] m, logic siw, int slp);
        if (m == can_pm_pkg::CPU_WAIT) return siw;
        if (m == can_pm_pkg::CPU_STOP3) return (slp == 0);
        return (m != can_pm_pkg::CPU_RUN);
    endfunction

    task automatic chk(input logic got, input logic exp, input string what);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t %s", $time, what);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic wait_ack(input logic v);
        k = 0;
        while (stat.sleep_acknowledge !== v && k < 30) begin
            cyc(1);
            k++;
        end
    endtask

    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Watchdog
    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        print_verdict();
    end

    // Main sequence
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        ctrl.sleep_request <= 1'b1;
        cyc(3);
        chk(stat.core_clk_en, 1'b0, "core clk while disabled");
        chk(stat.reg_clk_en, 1'b0, "reg clk while disabled");
        @(posedge clk_i);
        ctrl <= '0;
        ctrl.module_enable <= 1'b1;
        // Normal, listen-only and loopback with random transmit bits
        for (int m = 0; m < 3; m++) begin
            @(posedge clk_i);
            ctrl.listen_only <= (m == 1);
            ctrl.loopback <= (m == 2);
            mac_tx <= 1'b1;
            cyc(8);
            chk(tx_ok, m != 1, "tx permission");
            chk(stat.on_bus, 1'b1, "on bus in normal state");
            chk(ack_ign, m == 2, "ack ignore");
            for (i = 0; i < 16; i++) begin
                @(posedge clk_i);
                r = rnd();
                mac_tx <= r[0];
                q_exp.push_back((m == 0) ? r[0] : 1'b1);
                cyc(1);
                chk(pin_tx, q_exp.pop_front(), "tx pin");
                if (m != 0) chk(mac_rx, r[0], "internal rx");
            end
            @(posedge clk_i);
            tx_done <= 1'b1;
            @(posedge clk_i);
            tx_done <= 1'b0;
            #1;
            chk(tx_irq, 1'b1, "tx irq");
            chk(rx_irq, m == 2, "rx irq");
        end
        // Sleep request with busy buffers, then a reception in progress
        @(posedge clk_i);
        ctrl.listen_only <= 1'b0;
        ctrl.loopback <= 1'b0;
        mac_tx <= 1'b1;
        r = rnd();
        txe <= r[2:0] & 3'h6;
        rcv <= 1'b1;
        boff <= 1'b1;
        ctrl.sleep_request <= 1'b1;
        cyc(12);
        chk(stat.sleep_acknowledge, 1'b0, "ack with busy buffers");
        txe <= 3'h7;
        cyc(12);
        chk(stat.sleep_acknowledge, 1'b0, "ack while receiving");
        rcv <= 1'b0;
        wait_ack(1'b1);
        chk(k >= can_pm_pkg::SYNC_DELAY_CYC && k < 30, 1'b1, "sleep entry delay");
        m_sleep = 1;
        chk(stat.core_clk_en, 1'b0, "core clk in sleep");
        chk(stat.reg_clk_en, 1'b1, "reg clk in sleep");
        chk(fg_en, 1'b0, "fg move in sleep");
        chk(ab_en, 1'b0, "abort in sleep");
        chk(bo_en, 1'b0, "bus-off count in sleep");
        chk(pin_tx, 1'b1, "tx pin in sleep");
        @(posedge clk_i);
        bus.burst(8);
        cyc(10);
        chk(stat.sleep_acknowledge, 1'b1, "masked wake");
        chk(wk_irq, 1'b0, "masked wake irq");
        // Run and light stop keep the sleep state
        for (int m = 0; m < 3; m += 2) begin
            @(posedge clk_i);
            cpu_mode <= m[2:0];
            cyc(3);
            chk(pd, exp_pd(m[2:0], 1'b0, m_sleep), "pd from sleep");
        end
        @(posedge clk_i);
        cpu_mode <= can_pm_pkg::CPU_RUN;
        ctrl.sleep_request <= 1'b0;
        wait_ack(1'b0);
        chk(stat.sleep_acknowledge, 1'b0, "leave by software");
        m_sleep = 0;
        // Every cpu mode with both stop-in-wait values while awake, starting from resync
        for (int j = 0; j < 8; j++) begin
            @(posedge clk_i);
            cpu_mode <= j[2:0] >> 1;
            ctrl.stop_in_wait <= j[0];
            @(posedge clk_i);
            #1;
            chk(abort, exp_pd(j[2:0] >> 1, j[0], m_sleep), "abort on entry");
            cyc(1);
            chk(pd, exp_pd(j[2:0] >> 1, j[0], m_sleep), "power-down");
            cyc(1);
            chk(stat.reg_clk_en, !pd, "reg clk in power-down");
            chk(pin_tx, 1'b1, "tx pin");
            @(posedge clk_i);
            cpu_mode <= can_pm_pkg::CPU_RUN;
            cyc(4);
            chk(pd, 1'b0, "restart");
        end
        // Wake on bus activity, then resync over idle bits
        @(posedge clk_i);
        ctrl.stop_in_wait <= 1'b0;
        ctrl.wakeup_enable <= 1'b1;
        ctrl.wakeup_irq_enable <= 1'b1;
        ctrl.sleep_request <= 1'b1;
        wait_ack(1'b1);
        @(posedge clk_i);
        // Burst runs alongside so the one-cycle wake pulse is polled while it stands
        fork
            bus.burst(6);
        join_none
        k = 0;
        while (wk_irq !== 1'b1 && k < 30) begin
            cyc(1);
            k++;
        end
        chk(wk_irq, 1'b1, "wake irq");
        ctrl.sleep_request <= 1'b0;
        cyc(6);
        chk(stat.sleep_acknowledge, 1'b0, "awake");
        k = 0;
        for (i = 1; i <= can_pm_pkg::IDLE_BITS + 2; i++) begin
            @(posedge clk_i);
            tick <= 1'b1;
            @(posedge clk_i);
            tick <= 1'b0;
            cyc(2);
            if (tx_ok === 1'b1 && k == 0) k = i;
        end
        chk(k == can_pm_pkg::IDLE_BITS, 1'b1, "resync bit count");
        print_verdict();
    end
endmodule
